// file: rx_recovery_pkg.sv
// Shared constants for the asynchronous receive recovery block
package rx_recovery_pkg;
   localparam int          SAMPLES_NORMAL   = 16;
   localparam int          SAMPLES_DOUBLE   = 8;
   localparam logic [3:0]  VOTE_FIRST_NORMAL = 4'h8;
   localparam logic [3:0]  VOTE_FIRST_DOUBLE = 4'h4;
   localparam logic [3:0]  SAMPLE_FIRST      = 4'h1;
   localparam logic [3:0]  LAST_NORMAL       = 4'hf;
   localparam logic [3:0]  LAST_DOUBLE       = 4'h7;
   localparam logic [3:0]  BITS_MIN          = 4'h5;
   localparam logic [3:0]  BITS_MAX          = 4'ha;
   localparam int          DATA_MAX          = 10;
   localparam int          FIFO_DEPTH        = 8;
   localparam int          CLK_MHZ           = 40;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_START = 4'b0010,
      ST_BITS  = 4'b0100,
      ST_STOP  = 4'b1000
   } rx_state_type;
endpackage

// file: rx_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module rx_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fifo_state_type;

   fifo_state_type   st_reg;
   fifo_state_type   st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign count     = st_reg.wr - st_reg.rd;
   assign in_ready  = (count != DEPTH[AW:0]) && !flush;
   assign out_valid = (count != '0);
   assign out_data  = mem[st_reg.rd[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready && !flush;

   always_comb begin
      st_next = st_reg;
      if (flush) begin
         st_next = '0;
      end else begin
         if (push) st_next.wr = st_reg.wr + 1'b1;
         if (pop) st_next.rd = st_reg.rd + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
         if (push) mem[st_reg.wr[AW-1:0]] <= in_data;
      end
   end
endmodule

// file: uart_rx_recovery.sv
// Asynchronous receive clock and data recovery with frame buffer
//
// Overview of operation
// - Sample at 16x normal, 8x double speed
// - Double speed when double_speed_select is one
// - Falling edge starts detection, first low sample one
// - Start checked on samples 8-10 or 4-6
// - Majority high start is noise, resume search
// - Valid start resynchronizes timing every frame
// - Sixteen or eight states per bit
// - Bit is majority of three centre samples
// - Votes at 8,9,10 or 4,5,6
// - Recover through first stop bit only
// - Stop voting zero sets frame error flag
// - New start accepted right after stop vote
// - Character plus parity five to ten bits
// - Rate error split equally between ends
// - Enable cleared stops reception and flushes buffer
// - Frame error stored with its frame
`timescale 1ns/100ps
module uart_rx_recovery #(
   parameter int DATA_MAX = rx_recovery_pkg::DATA_MAX,
   parameter int DEPTH    = rx_recovery_pkg::FIFO_DEPTH
) (
   input  wire logic                CLK_SYS,
   input  wire logic                RST,
   input  wire logic                CE,
   input  wire logic                SAMPLE_TICK,
   input  wire logic                RX_LINE,
   input  wire logic                RECEIVER_ENABLE_BIT,
   input  wire logic                DOUBLE_SPEED_SELECT,
   input  wire logic [3:0]          FRAME_BITS,
   output logic      [DATA_MAX-1:0] RX_DATA,
   output logic                     FRAME_ERROR_FLAG,
   output logic                     RX_VALID,
   input  wire logic                RX_READY,
   output logic                     OVERRUN
);
   typedef struct packed {
      rx_recovery_pkg::rx_state_type state;
      logic                          line_q;
      logic [3:0]                    sample;
      logic [1:0]                    votes;
      logic [3:0]                    bit_idx;
      logic [DATA_MAX-1:0]           shift;
      logic                          push;
      logic                          ferr;
      logic                          overrun;
   } rx_type;

   rx_type                st_reg;
   rx_type                st_next;
   logic                  fifo_ready;
   logic [DATA_MAX:0]     fifo_out;
   logic [3:0]            vote_first;
   logic [3:0]            last_sample;
   logic [3:0]            nbits;
   logic                  in_vote;
   logic                  at_decide;
   logic                  bit_val;

   // Majority of two stored votes and the third sample
   function automatic logic majority(input logic [1:0] v, input logic s);
      majority = (v[0] & v[1]) | (v[0] & s) | (v[1] & s);
   endfunction

   // Centre votes leave equal slack for early and late remote edges
   assign vote_first  = DOUBLE_SPEED_SELECT ? rx_recovery_pkg::VOTE_FIRST_DOUBLE
                                            : rx_recovery_pkg::VOTE_FIRST_NORMAL;
   assign last_sample = DOUBLE_SPEED_SELECT ? rx_recovery_pkg::LAST_DOUBLE
                                            : rx_recovery_pkg::LAST_NORMAL;
   // Clamp frame length into the supported span
   assign nbits = (FRAME_BITS < rx_recovery_pkg::BITS_MIN) ? rx_recovery_pkg::BITS_MIN :
                  (FRAME_BITS > rx_recovery_pkg::BITS_MAX) ? rx_recovery_pkg::BITS_MAX : FRAME_BITS;
   assign in_vote   = (st_reg.sample >= vote_first) && (st_reg.sample <= vote_first + 4'h2);
   assign at_decide = (st_reg.sample == vote_first + 4'h2);
   assign bit_val   = majority(st_reg.votes, RX_LINE);

   always_comb begin
      st_next      = st_reg;
      st_next.push = 1'b0;
      // Successful store ends an overrun; a new drop below still wins
      if (st_reg.push) st_next.overrun = 1'b0;
      if (!RECEIVER_ENABLE_BIT) begin
         st_next.state = rx_recovery_pkg::ST_IDLE;
         st_next.line_q  = 1'b1;
         st_next.overrun = 1'b0;
      end else if (SAMPLE_TICK) begin
         st_next.line_q = RX_LINE;
         st_next.sample = st_reg.sample + 4'h1;
         if (in_vote) st_next.votes = {st_reg.votes[0], RX_LINE};
         case (st_reg.state)
            rx_recovery_pkg::ST_IDLE: begin
               if (st_reg.line_q && !RX_LINE) begin
                  st_next.state  = rx_recovery_pkg::ST_START;
                  st_next.sample = rx_recovery_pkg::SAMPLE_FIRST + 4'h1;
               end
            end
            rx_recovery_pkg::ST_START: begin
               if (at_decide) begin
                  if (bit_val) begin
                     st_next.state = rx_recovery_pkg::ST_IDLE;
                  end else begin
                     // Align so the next bit begins at sample one
                     st_next.state   = rx_recovery_pkg::ST_BITS;
                     st_next.bit_idx = '0;
                     st_next.shift   = '0;
                  end
               end
               // Zero stands for the last state, so a bit spans all its samples
               if (st_reg.sample == last_sample) st_next.sample = rx_recovery_pkg::SAMPLE_FIRST - 4'h1;
            end
            rx_recovery_pkg::ST_BITS: begin
               if (at_decide) begin
                  st_next.shift   = st_reg.shift | (DATA_MAX'(bit_val) << st_reg.bit_idx);
                  st_next.bit_idx = st_reg.bit_idx + 4'h1;
               end
               if (st_reg.sample == last_sample) begin
                  st_next.sample = rx_recovery_pkg::SAMPLE_FIRST - 4'h1;
                  if (st_reg.bit_idx == nbits) st_next.state = rx_recovery_pkg::ST_STOP;
               end
            end
            rx_recovery_pkg::ST_STOP: begin
               if (at_decide) begin
                  st_next.ferr  = !bit_val;
                  st_next.push  = fifo_ready;
                  st_next.state = rx_recovery_pkg::ST_IDLE;
                  st_next.line_q = 1'b1;
                  if (!fifo_ready) st_next.overrun = 1'b1;
               end
            end
            default: st_next.state = rx_recovery_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         st_reg        <= '0;
         st_reg.state  <= rx_recovery_pkg::ST_IDLE;
         st_reg.line_q <= 1'b1;
      end else if (CE) begin
         st_reg <= st_next;
      end
   end

   rx_fifo #(
      .WIDTH (DATA_MAX + 1),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (CLK_SYS),
      .rst       (RST),
      .ce        (CE),
      .flush     (!RECEIVER_ENABLE_BIT),
      .in_data   ({st_reg.ferr, st_reg.shift}),
      .in_valid  (st_reg.push),
      .in_ready  (fifo_ready),
      .out_data  (fifo_out),
      .out_valid (RX_VALID),
      .out_ready (RX_READY)
   );

   assign RX_DATA          = fifo_out[DATA_MAX-1:0];
   assign FRAME_ERROR_FLAG = fifo_out[DATA_MAX];
   assign OVERRUN          = st_reg.overrun;
endmodule

// file: uart_remote_tx.sv
// Behavioural remote transmitter driving the serial receive line
`timescale 1ns/100ps
module uart_remote_tx (
   input  wire logic clk,
   input  wire logic tick,
   output logic      line
);
   initial line = 1'b1;
   // Value i of a run is seen by the receiver at its sample i
   task automatic hold_ticks(input logic v, input int n, input int flip);
      for (int i = 1; i <= n; i++) begin
         @(posedge clk iff tick);
         line <= (i == flip) ? !v : v;
      end
   endtask
   task automatic send(input logic [9:0] d, input int nb, input int spb, input logic stop, input int flip,
                       input int gap);
      hold_ticks(1'b0, spb, 0);
      for (int b = 0; b < nb; b++) begin
         hold_ticks(d[b], spb, flip);
      end
      hold_ticks(stop, spb / 2 + 2, 0);
      hold_ticks(1'b1, gap, 0);
   endtask
endmodule

// file: uart_rx_recovery_asserts.sv
// Port-level assertions for the receive recovery block
`timescale 1ns/100ps
module uart_rx_recovery_asserts #(
   parameter int DATA_MAX = 10
) (
   input wire logic                CLK_SYS,
   input wire logic                RST,
   input wire logic                CE,
   input wire logic                SAMPLE_TICK,
   input wire logic                RECEIVER_ENABLE_BIT,
   input wire logic [DATA_MAX-1:0] RX_DATA,
   input wire logic                FRAME_ERROR_FLAG,
   input wire logic                RX_VALID,
   input wire logic                RX_READY,
   input wire logic                OVERRUN
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);
   sequence s_off;
      CE && !RECEIVER_ENABLE_BIT;
   endsequence
   sequence s_held;
      RX_VALID && $stable(RX_DATA) && $stable(FRAME_ERROR_FLAG);
   endsequence
   sequence s_quiet;
      !RX_VALID [*8];
   endsequence
   property p_rst;
      disable iff (1'b0) RST |=> !RX_VALID && !OVERRUN;
   endproperty
   property p_flush;
      s_off |=> !RX_VALID;
   endproperty
   property p_ovr_clr;
      s_off |=> !OVERRUN;
   endproperty
   property p_hold;
      CE && RECEIVER_ENABLE_BIT && RX_VALID && !RX_READY |=> s_held;
   endproperty
   property p_freeze;
      !CE |=> $stable(RX_VALID) && $stable(OVERRUN) && $stable(RX_DATA);
   endproperty
   property p_push;
      $rose(RX_VALID) |-> $past(SAMPLE_TICK) || $past(SAMPLE_TICK, 2) || $past(SAMPLE_TICK, 3);
   endproperty
   property p_ovr_full;
      $rose(OVERRUN) |-> $past(RX_VALID);
   endproperty
   property p_boot;
      $fell(RST) |-> s_quiet;
   endproperty
   a_rst: assert property (p_rst) else $error("reset left outputs set");
   a_flush: assert property (p_flush) else $error("buffer kept on disable");
   a_ovr_clr: assert property (p_ovr_clr) else $error("overrun kept on disable");
   a_hold: assert property (p_hold) else $error("frame moved while unread");
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
   a_push: assert property (p_push) else $error("frame not tied to a sample");
   a_ovr_full: assert property (p_ovr_full) else $error("overrun with empty buffer");
   a_boot: assert property (p_boot) else $error("frame without start bit");
endmodule
bind uart_rx_recovery uart_rx_recovery_asserts #(.DATA_MAX(DATA_MAX)) chk (.*);

// file: uart_rx_recovery_tb.sv
// Self-checking bench for the receive recovery block
`timescale 1ns/100ps
module uart_rx_recovery_tb;
   logic        CLK_SYS = 1'b0, RST = 1'b1, CE = 1'b1, SAMPLE_TICK = 1'b0, RECEIVER_ENABLE_BIT = 1'b1;
   logic        DOUBLE_SPEED_SELECT = 1'b0, RX_READY = 1'b0, stall = 1'b0;
   logic        RX_LINE, FRAME_ERROR_FLAG, RX_VALID, OVERRUN;
   logic [1:0]  tick_cnt = 2'h0;
   logic [3:0]  FRAME_BITS = 4'h8;
   logic [9:0]  RX_DATA;
   logic [10:0] exp_q[$];
   int          err_count = 0, num_checks = 0;
   always #12.5 CLK_SYS = !CLK_SYS;
   always @(posedge CLK_SYS) begin
      tick_cnt <= tick_cnt + 2'h1;
      SAMPLE_TICK <= tick_cnt == 2'h2;
      RX_READY <= !stall && 1'($urandom);
   end
   uart_rx_recovery dut (.*);
   uart_remote_tx tx (.clk(CLK_SYS), .tick(SAMPLE_TICK), .line(RX_LINE));
   task automatic check(input logic [10:0] seen, input logic [10:0] want);
      num_checks++;
      if (seen !== want) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic stop_test();
      if (err_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic frame(input int nb, input logic ds, input logic stop, input int flip, input int gap,
                        input logic keep);
      logic [9:0] d;
      d = 10'($urandom) & ((10'h1 << nb) - 10'h1);
      FRAME_BITS <= 4'(nb);
      DOUBLE_SPEED_SELECT <= ds;
      if (keep)
         exp_q.push_back({!stop, d});
      tx.send(d, nb, ds ? 8 : 16, stop, flip, gap);
   endtask
   task automatic glitch(input int n);
      tx.hold_ticks(1'b0, n, 0);
      tx.hold_ticks(1'b1, 24, 0);
   endtask
   task automatic drain();
      for (int i = 0; i < 4000 && exp_q.size() > 0; i++) @(posedge CLK_SYS);
   endtask
   always @(posedge CLK_SYS) begin
      if (RX_VALID === 1'b1 && RX_READY === 1'b1 && CE && RECEIVER_ENABLE_BIT && !RST)
         check({FRAME_ERROR_FLAG, RX_DATA}, exp_q.size() > 0 ? exp_q.pop_front() : 11'hx);
   end
   initial begin
      void'($urandom(32'h850a));
      repeat (2) @(posedge CLK_SYS);
      RST <= 1'b0;
      for (int m = 0; m < 2; m++) begin
         for (int nb = 5; nb <= 10; nb++) begin
            frame(nb, m[0], 1'b1, 0, 2, 1'b1);
         end
      end
      frame(8, 1'b0, 1'b0, 0, 0, 1'b1);
      frame(8, 1'b0, 1'b1, 9, 2, 1'b1);
      frame(7, 1'b1, 1'b0, 0, 0, 1'b1);
      frame(7, 1'b1, 1'b1, 5, 2, 1'b1);
      glitch(4);
      DOUBLE_SPEED_SELECT <= 1'b0;
      glitch(8);
      drain();
      stall <= 1'b1;
      repeat (9) frame(6, 1'b0, 1'b1, 0, 2, exp_q.size() < 8);
      @(posedge CLK_SYS);
      check({10'h0, OVERRUN}, 11'h1);
      CE <= 1'b0;
      repeat (6) @(posedge CLK_SYS);
      CE <= 1'b1;
      fork
         frame(6, 1'b0, 1'b1, 0, 2, 1'b0);
         begin
            repeat (200) @(posedge CLK_SYS);
            RECEIVER_ENABLE_BIT <= 1'b0;
         end
      join
      @(posedge CLK_SYS);
      check({9'h0, RX_VALID, OVERRUN}, 11'h0);
      exp_q.delete();
      RECEIVER_ENABLE_BIT <= 1'b1;
      stall <= 1'b0;
      frame(10, 1'b0, 1'b1, 0, 2, 1'b1);
      drain();
      check(11'(exp_q.size()), 11'h0);
      stop_test();
   end
   initial begin
      repeat (60000) @(posedge CLK_SYS);
      err_count++;
      stop_test();
   end
endmodule
